//--- hw/spc_pkg.sv
package spc_pkg;
   // Widths of the position path and of the status objects
   localparam int POS_W = 32;
   localparam int BYTE_W = 8;
   localparam int IDX_W = 16;
   // Object indices of the two status bytes
   localparam logic [IDX_W-1:0] IDX_DIRECTION = 16'h5802;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 16'h5803;
   // Bit positions in the direction byte
   localparam int UP_BIT = 7;
   localparam int DN_BIT = 6;
   // Bit positions in the flags byte
   localparam int MATCH_ONE_BIT = 3;
   localparam int MATCH_TWO_BIT = 4;
   localparam int OVER_BIT = 5;
   localparam int UNDER_BIT = 6;
   // Reset and filler values
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [POS_W-1:0] POS_ZERO = 32'h0000_0000;

   // Direction byte: all bits but the two indicators read zero
   function automatic logic [BYTE_W-1:0] build_direction(input logic up, input logic dn);
      logic [BYTE_W-1:0] b;
      b = BYTE_ZERO;
      b[UP_BIT] = up;
      b[DN_BIT] = dn;
      return b;
   endfunction : build_direction

   // Flags byte: markers and limit bits, the rest zero
   function automatic logic [BYTE_W-1:0] build_flags(input logic m1, input logic m2,
                                                      input logic ov, input logic un);
      logic [BYTE_W-1:0] b;
      b = BYTE_ZERO;
      b[MATCH_ONE_BIT] = m1;
      b[MATCH_TWO_BIT] = m2;
      b[OVER_BIT] = ov;
      b[UNDER_BIT] = un;
      return b;
   endfunction : build_flags
endpackage : spc_pkg

//--- hw/spc_match_marker.sv
`timescale 1ns/1ps
`default_nettype none
module spc_match_marker (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_sample_valid, // New position sample this cycle
   input wire logic i_equal, // Position equals compare value
   input wire logic i_clear, // Clear request, level
   output logic o_marker
);
   // Marker state: the sticky bit and the equality of the last sample
   typedef struct packed {
      logic marker;
      logic equal_held;
   } spc_marker_s;

   spc_marker_s state_reg;
   spc_marker_s state_next;

   // Next state: a new match sets, a clear drops the marker only when no match holds
   always_comb begin
      state_next = state_reg;
      if (i_sample_valid) begin
         state_next.equal_held = i_equal;
      end
      if (i_sample_valid && i_equal) begin
         // Set wins over any clear in the same cycle
         state_next.marker = 1'b1; // [R8] [R9]
      end else if (i_clear && !state_reg.equal_held) begin
         state_next.marker = 1'b0; // [R6] [R10] [R11]
      end
      // Otherwise a clear while the match still holds leaves the marker set [R7]
   end

   // State register
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_marker = state_reg.marker;

   // A match on a sample sets the marker at the next edge
   property p_match_sets;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_sample_valid && i_equal) |=> o_marker;
   endproperty
   a_match_sets: assert property (p_match_sets) else $error("marker not set after match"); // [R8]

   // A clear with no standing match and no new match drops the marker
   property p_clear_drops;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_clear && !state_reg.equal_held && !(i_sample_valid && i_equal)) |=> !o_marker;
   endproperty
   a_clear_drops: assert property (p_clear_drops) else $error("marker not cleared"); // [R10]

   // A clear while the match still holds keeps the marker
   property p_clear_kept;
      @(posedge i_clock) disable iff (!i_rstn)
      (o_marker && i_clear && state_reg.equal_held) |=> o_marker;
   endproperty
   a_clear_kept: assert property (p_clear_kept) else $error("marker lost while match holds"); // [R7]

   // Without clear the marker is sticky, without match it never rises
   property p_sticky;
      @(posedge i_clock) disable iff (!i_rstn)
      (!i_clear && o_marker) |=> o_marker;
   endproperty
   a_sticky: assert property (p_sticky) else $error("marker dropped without clear"); // [R9]

   property p_no_spurious;
      @(posedge i_clock) disable iff (!i_rstn)
      (!o_marker && !(i_sample_valid && i_equal)) |=> !o_marker;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("marker set without match"); // [R8]

   // Main scenario: set, then cleared
   property p_cov_set_clear;
      @(posedge i_clock) disable iff (!i_rstn)
      o_marker ##1 !o_marker;
   endproperty
   c_set_clear: cover property (p_cov_set_clear);
endmodule : spc_match_marker
`default_nettype wire

//--- hw/spc_top.sv
// Behaviour
// R1: Direction byte: up bit7, down bit6, rest zero
// R2: Up set on rising samples, else cleared
// R3: Down set on falling samples, else cleared
// R4: Flags byte: markers bits3/4, over5, under6
// R5: Over and under bits are live, not latched
// R6: Any write to flags byte clears markers
// R7: Clear ignored while marker's match still holds
// R8: Marker one latches on position equal compare one
// R9: Marker two latches on position equal compare two
// R10: Clear-one process bit resets marker one
// R11: Clear-two process bit resets marker two
// R12: Under bit set when position below lower limit
// R13: Over bit set when position above upper limit
// R14: Results update once per new position sample
`timescale 1ns/1ps
`default_nettype none
module spc_top (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_sample_valid, // One-cycle pulse: new position sample
   input wire logic [spc_pkg::POS_W-1:0] i_position, // Current position value
   input wire logic [spc_pkg::POS_W-1:0] i_compare_value_one,
   input wire logic [spc_pkg::POS_W-1:0] i_compare_value_two,
   input wire logic [spc_pkg::POS_W-1:0] i_upper_limit,
   input wire logic [spc_pkg::POS_W-1:0] i_lower_limit,
   input wire logic i_clear_match_one, // Process output clear bit, level
   input wire logic i_clear_match_two, // Process output clear bit, level
   input wire logic i_obj_read, // Object read strobe
   input wire logic i_obj_write, // Object write strobe
   input wire logic [spc_pkg::IDX_W-1:0] i_obj_index, // Object index
   input wire logic [spc_pkg::BYTE_W-1:0] i_obj_wdata, // Written value, ignored
   output logic [spc_pkg::BYTE_W-1:0] o_direction_status_byte, // Process input copy
   output logic [spc_pkg::BYTE_W-1:0] o_compare_limit_flags_byte, // Process input copy
   output logic o_obj_ack, // One-cycle answer to an access
   output logic o_obj_err, // With ack: unmapped index or write to read-only
   output logic [spc_pkg::BYTE_W-1:0] o_obj_rdata // Read value, valid with ack
);
   // All state of the top in one record
   typedef struct packed {
      logic [spc_pkg::POS_W-1:0] prev_position; // Last sample, for direction
      logic have_prev; // First sample has no predecessor
      logic count_up_indicator;
      logic count_down_indicator;
      logic above_upper_limit;
      logic below_lower_limit;
      logic ack;
      logic err;
      logic [spc_pkg::BYTE_W-1:0] rdata;
   } spc_top_s;

   spc_top_s state_reg;
   spc_top_s state_next;

   logic match_marker_one; // Sticky marker outputs, registered in the leaf
   logic match_marker_two;
   logic flags_write; // Any write to the flags object
   logic hit_direction; // Index decode
   logic hit_flags;
   logic [spc_pkg::BYTE_W-1:0] direction_byte;
   logic [spc_pkg::BYTE_W-1:0] flags_byte;

   // Object index decode; the written value is deliberately not looked at
   assign hit_direction = (i_obj_index == spc_pkg::IDX_DIRECTION);
   assign hit_flags = (i_obj_index == spc_pkg::IDX_FLAGS);
   assign flags_write = i_obj_write && hit_flags; // [R6]

   // Bytes are built only from flops and constant zeros
   assign direction_byte = spc_pkg::build_direction(state_reg.count_up_indicator,
                                                    state_reg.count_down_indicator); // [R1]
   assign flags_byte = spc_pkg::build_flags(match_marker_one, match_marker_two,
                                            state_reg.above_upper_limit,
                                            state_reg.below_lower_limit); // [R4]

   // Marker one: cleared by a flags write or its process output bit
   spc_match_marker u_marker_one (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_sample_valid(i_sample_valid),
      .i_equal(i_position == i_compare_value_one), // [R8]
      .i_clear(flags_write || i_clear_match_one), // [R10]
      .o_marker(match_marker_one)
   );

   // Marker two, same structure against the second compare value
   spc_match_marker u_marker_two (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_sample_valid(i_sample_valid),
      .i_equal(i_position == i_compare_value_two), // [R9]
      .i_clear(flags_write || i_clear_match_two), // [R11]
      .o_marker(match_marker_two)
   );

   // Next state: sample evaluation and object access answer
   always_comb begin
      state_next = state_reg;
      state_next.ack = 1'b0;
      state_next.err = 1'b0;
      // Everything derived from the position moves only on a new sample
      if (i_sample_valid) begin // [R14]
         state_next.prev_position = i_position;
         state_next.have_prev = 1'b1;
         // First sample after reset shows no direction, there is nothing to compare with
         state_next.count_up_indicator = state_reg.have_prev &&
                                         (i_position > state_reg.prev_position); // [R2]
         state_next.count_down_indicator = state_reg.have_prev &&
                                           (i_position < state_reg.prev_position); // [R3]
         // Live comparisons, overwritten every sample, never held
         state_next.above_upper_limit = (i_position > i_upper_limit); // [R13] [R5]
         state_next.below_lower_limit = (i_position < i_lower_limit); // [R12] [R5]
      end
      // Access answer one cycle after the strobe; write wins if both are given
      if (i_obj_write) begin
         state_next.ack = 1'b1;
         state_next.err = !hit_flags;
         state_next.rdata = spc_pkg::BYTE_ZERO;
      end else if (i_obj_read) begin
         state_next.ack = 1'b1;
         if (hit_direction) begin
            state_next.rdata = direction_byte;
         end else if (hit_flags) begin
            state_next.rdata = flags_byte;
         end else begin
            // Unmapped index reads zero and flags an error
            state_next.err = 1'b1;
            state_next.rdata = spc_pkg::BYTE_ZERO;
         end
      end
   end

   // State register, constants only under reset
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_direction_status_byte = direction_byte;
   assign o_compare_limit_flags_byte = flags_byte;
   assign o_obj_ack = state_reg.ack;
   assign o_obj_err = state_reg.err;
   assign o_obj_rdata = state_reg.rdata;

   // Unused bits of the direction byte stay zero and both indicators never rise together
   property p_direction_layout;
      @(posedge i_clock) disable iff (!i_rstn)
      (o_direction_status_byte[spc_pkg::DN_BIT-1:0] == '0) &&
      !(o_direction_status_byte[spc_pkg::UP_BIT] && o_direction_status_byte[spc_pkg::DN_BIT]);
   endproperty
   a_direction_layout: assert property (p_direction_layout) else $error("direction byte layout"); // [R1]

   // Rising sample gives up indicator at the next edge
   property p_up;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_sample_valid && state_reg.have_prev) |=>
      (o_direction_status_byte[spc_pkg::UP_BIT] == ($past(i_position) > $past(state_reg.prev_position)));
   endproperty
   a_up: assert property (p_up) else $error("up indicator wrong"); // [R2]

   // Falling sample gives down indicator at the next edge
   property p_down;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_sample_valid && state_reg.have_prev) |=>
      (o_direction_status_byte[spc_pkg::DN_BIT] == ($past(i_position) < $past(state_reg.prev_position)));
   endproperty
   a_down: assert property (p_down) else $error("down indicator wrong"); // [R3]

   // Flags byte zero bits
   property p_flags_layout;
      @(posedge i_clock) disable iff (!i_rstn)
      !o_compare_limit_flags_byte[spc_pkg::UNDER_BIT+1] &&
      (o_compare_limit_flags_byte[spc_pkg::MATCH_ONE_BIT-1:0] == '0);
   endproperty
   a_flags_layout: assert property (p_flags_layout) else $error("flags byte layout"); // [R4]

   // Limit bits follow the last sample exactly
   property p_over;
      @(posedge i_clock) disable iff (!i_rstn)
      i_sample_valid |=> (o_compare_limit_flags_byte[spc_pkg::OVER_BIT] ==
                          ($past(i_position) > $past(i_upper_limit)));
   endproperty
   a_over: assert property (p_over) else $error("over bit wrong"); // [R13]

   property p_under;
      @(posedge i_clock) disable iff (!i_rstn)
      i_sample_valid |=> (o_compare_limit_flags_byte[spc_pkg::UNDER_BIT] ==
                          ($past(i_position) < $past(i_lower_limit)));
   endproperty
   a_under: assert property (p_under) else $error("under bit wrong"); // [R12]

   // Between samples the derived bits do not move
   property p_hold;
      @(posedge i_clock) disable iff (!i_rstn)
      !i_sample_valid |=> $stable(o_direction_status_byte) &&
                          $stable(o_compare_limit_flags_byte[spc_pkg::UNDER_BIT:spc_pkg::OVER_BIT]);
   endproperty
   a_hold: assert property (p_hold) else $error("status moved without sample"); // [R14]

   // A flags write with no standing or new match clears marker one
   property p_write_clears;
      @(posedge i_clock) disable iff (!i_rstn)
      (flags_write && !i_sample_valid && !u_marker_one.state_reg.equal_held) |=>
      !o_compare_limit_flags_byte[spc_pkg::MATCH_ONE_BIT];
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("flags write did not clear"); // [R6]

   // Every access is answered on the next edge only
   property p_ack;
      @(posedge i_clock) disable iff (!i_rstn)
      (i_obj_read || i_obj_write) |=> o_obj_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("access not acknowledged");

   // Main scenarios
   property p_cov_up_then_down;
      @(posedge i_clock) disable iff (!i_rstn)
      o_direction_status_byte[spc_pkg::UP_BIT] ##[1:20] o_direction_status_byte[spc_pkg::DN_BIT];
   endproperty
   c_up_then_down: cover property (p_cov_up_then_down);

   property p_cov_over;
      @(posedge i_clock) disable iff (!i_rstn)
      o_compare_limit_flags_byte[spc_pkg::OVER_BIT] ##1 !o_compare_limit_flags_byte[spc_pkg::OVER_BIT];
   endproperty
   c_over: cover property (p_cov_over);

   property p_cov_flags_write;
      @(posedge i_clock) disable iff (!i_rstn)
      flags_write && o_compare_limit_flags_byte[spc_pkg::MATCH_TWO_BIT];
   endproperty
   c_flags_write: cover property (p_cov_flags_write);
endmodule : spc_top
`default_nettype wire

//--- tb/spc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fieldbus master: accesses the status objects and drives the clear bits
module spc_master_model (
   input wire logic i_clock,
   input wire logic i_ack,
   input wire logic [7:0] i_rdata,
   output logic o_read,
   output logic o_write,
   output logic [15:0] o_index,
   output logic [7:0] o_wdata,
   output logic o_clear_one,
   output logic o_clear_two
);
   // Quiet bus at time zero
   initial begin
      o_read = 1'b0;
      o_write = 1'b0;
      o_index = 16'h0000;
      o_wdata = 8'h00;
      o_clear_one = 1'b0;
      o_clear_two = 1'b0;
   end

   // One object access; the strobe stands for one edge, ack waited on with a bound
   task automatic access(input logic wr, input logic [15:0] idx, output logic [7:0] d, output logic ok);
      int n;
      n = 0;
      @(negedge i_clock);
      o_write = wr;
      o_read = !wr;
      o_index = idx;
      o_wdata = ~idx[7:0]; // Written value is arbitrary
      @(negedge i_clock);
      o_write = 1'b0;
      o_read = 1'b0;
      o_index = ~idx; // Released index shows a stale-proof pattern
      o_wdata = idx[7:0];
      while (i_ack !== 1'b1 && n < 4) begin
         @(negedge i_clock);
         n++;
      end
      d = i_rdata;
      ok = (n < 4);
   endtask : access

   // Clear bits raised in the process output for one cycle
   task automatic clear(input logic one, input logic two);
      @(negedge i_clock);
      o_clear_one = one;
      o_clear_two = two;
      @(negedge i_clock);
      o_clear_one = 1'b0;
      o_clear_two = 1'b0;
   endtask : clear
endmodule : spc_master_model
`default_nettype wire

//--- tb/ssi_position_compare_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_position_compare_status_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic valid = 1'b0;
   logic [31:0] pos = 32'h0000_0000;
   // Compare values and limits, moved only between samples
   logic [31:0] cmp1 = 32'h0000_0032;
   logic [31:0] cmp2 = 32'h0000_0046;
   logic [31:0] upper = 32'h0000_0064;
   logic [31:0] lower = 32'h0000_0014;
   logic rd, wr, clr1, clr2, ack, err, got_ok;
   logic [15:0] idx;
   logic [7:0] wdat, rdata, dir, flg, got_d;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   // One row: sample value, then direction and flags bytes it should leave
   typedef struct packed {logic [31:0] p; logic [7:0] d; logic [7:0] f;} spc_row_s;
   // Limits 20..100, compare values 50 and 70; boundaries on purpose
   spc_row_s rows [9] = '{'{32'h1E, 8'h00, 8'h00}, '{32'h0A, 8'h40, 8'h40}, '{32'h0A, 8'h00, 8'h40},
      '{32'h14, 8'h80, 8'h00}, '{32'h32, 8'h80, 8'h08}, '{32'h64, 8'h80, 8'h08},
      '{32'h65, 8'h80, 8'h28}, '{32'h46, 8'h40, 8'h18}, '{32'h3C, 8'h40, 8'h18}};

   // 250 MHz clock
   always #2 clock = ~clock;

   spc_top u_dut (.i_clock(clock), .i_rstn(rstn), .i_sample_valid(valid), .i_position(pos),
      .i_compare_value_one(cmp1), .i_compare_value_two(cmp2),
      .i_upper_limit(upper), .i_lower_limit(lower),
      .i_clear_match_one(clr1), .i_clear_match_two(clr2), .i_obj_read(rd), .i_obj_write(wr),
      .i_obj_index(idx), .i_obj_wdata(wdat), .o_direction_status_byte(dir),
      .o_compare_limit_flags_byte(flg), .o_obj_ack(ack), .o_obj_err(err), .o_obj_rdata(rdata));

   spc_master_model u_master (.i_clock(clock), .i_ack(ack), .i_rdata(rdata), .o_read(rd),
      .o_write(wr), .o_index(idx), .o_wdata(wdat), .o_clear_one(clr1), .o_clear_two(clr2));

   // Hang guard: far above the 70 or so cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   // Byte results
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk_byte

   // Single-bit results such as the error answer
   task automatic chk_bit(input logic got, input logic exp, input string m);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %b want %b", $time, m, got, exp);
      end
   endtask : chk_bit

   // One position sample, one cycle wide
   task automatic sample(input logic [31:0] p);
      @(negedge clock);
      valid = 1'b1;
      pos = p;
      @(negedge clock);
      valid = 1'b0;
   endtask : sample

   // Object access plus its answer checks
   task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] d, input logic e);
      u_master.access(w, i, got_d, got_ok);
      chk_bit(got_ok, 1'b1, "ack");
      chk_bit(err, e, "err");
      chk_byte(got_d, d, "rdata");
   endtask : obj

   // Verdict, the only place the run ends
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      // Table of ordinary samples
      foreach (rows[i]) begin
         sample(rows[i].p);
         chk_byte(dir, rows[i].d, "direction");
         chk_byte(flg, rows[i].f, "flags");
      end
      $display("test sample table done");
      // Position moves without a sample: nothing may follow it
      @(negedge clock);
      pos = 32'h0000_01F4;
      repeat (2) @(negedge clock);
      chk_byte(flg, 8'h18, "no sample");
      chk_byte(dir, 8'h40, "no sample dir");
      $display("test hold between samples done");
      // Object reads, refused accesses, flags write
      obj(1'b0, 16'h5803, 8'h18, 1'b0);
      obj(1'b0, 16'h5802, 8'h40, 1'b0);
      obj(1'b1, 16'h5802, 8'h00, 1'b1);
      obj(1'b0, 16'h5804, 8'h00, 1'b1);
      obj(1'b1, 16'h5803, 8'h00, 1'b0);
      chk_byte(flg, 8'h00, "after write");
      $display("test object access done");
      // Clear while the match still holds keeps the marker
      sample(32'h32);
      obj(1'b1, 16'h5803, 8'h00, 1'b0);
      chk_byte(flg, 8'h08, "held on write");
      u_master.clear(1'b1, 1'b0);
      chk_byte(flg, 8'h08, "held on clear");
      // Clear bits act on their own marker only
      sample(32'h46);
      sample(32'h3C);
      chk_byte(flg, 8'h18, "both set");
      u_master.clear(1'b0, 1'b1);
      chk_byte(flg, 8'h08, "clear two");
      u_master.clear(1'b1, 1'b0);
      chk_byte(flg, 8'h00, "clear one");
      $display("test marker clear done");
      // Reset mid-run, then the first sample has no predecessor
      @(negedge clock);
      rstn = 1'b0;
      @(negedge clock);
      chk_byte(dir, 8'h00, "in reset");
      chk_byte(flg, 8'h00, "in reset flags");
      rstn = 1'b1;
      sample(32'h50);
      chk_byte(dir, 8'h00, "first sample");
      chk_byte(flg, 8'h00, "first flags");
      $display("test reset done");
      // Limits and compare values count as they stand on the sample that uses them
      @(negedge clock);
      upper = 32'h0000_004F;
      cmp1 = 32'h0000_0050;
      sample(32'h50);
      chk_byte(dir, 8'h00, "constant dir");
      chk_byte(flg, 8'h28, "moved upper and compare");
      @(negedge clock);
      upper = 32'h0000_0060;
      lower = 32'h0000_0052;
      sample(32'h51);
      chk_byte(dir, 8'h80, "up after move");
      chk_byte(flg, 8'h48, "moved lower");
      $display("test moving limits done");
      wrap_up();
   end
endmodule : ssi_position_compare_status_tb
`default_nettype wire
